// ### rtl/cic_step.sv
// One input step of a cascaded integrator-comb filter of order 1 to 4
module cic_step (
  input wire logic [2:0] order,
  input wire logic dump,
  input wire logic [31:0] x,
  input wire logic [3:0][31:0] integ_in,
  input wire logic [3:0][31:0] comb_in,
  output logic [3:0][31:0] integ_out,
  output logic [3:0][31:0] comb_out,
  output logic [31:0] y
);

  // Integrators every step, combs only on the decimated output step
  always_comb begin
    logic [31:0] acc;
    logic [2:0] n;
    acc = x;
    n = (order > 3'h4) ? 3'h4 : order;
    y = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      if (3'(k) < n) begin
        integ_out[k] = integ_in[k] + acc;
        acc = integ_out[k];
      end else begin
        integ_out[k] = integ_in[k];
      end
    end
    y = acc;
    for (int k = 0; k < 4; k++) begin
      if (dump && (3'(k) < n)) begin
        comb_out[k] = y;
        y = y - comb_in[k];
      end else begin
        comb_out[k] = comb_in[k];
      end
    end
  end

endmodule : cic_step

// ### rtl/slot_accumulate_decimate_path.sv
// Top of the per-slot accumulate, decimate and result path
module slot_accumulate_decimate_path (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic slot_start,
  input wire logic slot_end,
  input wire logic [3:0] slot_id,
  input wire logic seq_end,
  input wire logic smp_valid,
  input wire logic [13:0] smp_data,
  input wire logic pulse_negate_select,
  input wire logic smp_dark_region,
  input wire logic [9:0] fifo_space,
  output logic fifo_wr_valid,
  output logic [31:0] fifo_wr_data,
  output logic [11:0] slot_run_mask,
  output logic busy,
  output logic [11:0] data_flags,
  output logic queue_overrun_flag
);

  // ***************************************
  // Types and helpers
  // ***************************************
  typedef enum logic [3:0] {
    EMIT_IDLE = 4'b0001,
    EMIT_SCAN = 4'b0010,
    EMIT_DARK = 4'b0100,
    EMIT_SIG = 4'b1000
  } emit_state_type;

  // Saturating unsigned add of a conversion result
  function automatic logic [31:0] sat_add(input logic [31:0] a,
                                          input logic [13:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {19'h0_0000, b};
    return s[32] ? 32'hffff_ffff : s[31:0];
  endfunction : sat_add

  // Clip a value to non-negative when viewed as signed
  function automatic logic [31:0] clip_pos(input logic [31:0] v);
    return v[31] ? 32'h0000_0000 : v;
  endfunction : clip_pos

  // Count of set bits in a slot mask
  function automatic logic [3:0] ones(input logic [11:0] m);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 12; i++) begin
      c = c + {3'h0, m[i]};
    end
    return c;
  endfunction : ones

  // Decode of a per-slot register window
  function automatic logic in_window(input logic [7:0] a,
                                     input logic [7:0] base);
    return (a >= base) && (a < base + 8'h0c);
  endfunction : in_window

  // ***************************************
  // Registers
  // ***************************************
  slot_path_pkg::slot_cfg_type cfg_q [12];
  slot_path_pkg::slot_shift_type shift_q [12];
  logic [31:0] dark_reg_q [12];
  logic [31:0] signal_reg_q [12];
  logic [11:0] enable_q;
  logic [11:0] hold_q;
  logic [7:0] seq_cnt_q [12];
  logic [31:0] pos_q;
  logic [31:0] neg_q;
  logic [11:0] ready_q;
  logic [11:0] ready_snap_q;
  logic space_ok_q;
  logic [3:0] emit_idx_q;
  emit_state_type emit_q;
  logic [11:0] flag_set;
  logic overrun_set;

  // ***************************************
  // Register port
  // ***************************************
  logic [3:0] wr_slot;
  logic [3:0] rd_slot;
  assign wr_slot = reg_addr[3:0];
  assign rd_slot = reg_addr[3:0];

  // Per-slot configuration writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 12; i++) begin
        cfg_q[i] <= '0;
        shift_q[i] <= '0;
      end
    end else if (reg_wr) begin
      if (in_window(reg_addr, slot_path_pkg::ADDR_CFG_BASE)) begin
        cfg_q[wr_slot] <= reg_wdata[12:0];
      end else if (in_window(reg_addr, slot_path_pkg::ADDR_SHIFT_BASE)) begin
        shift_q[wr_slot] <= reg_wdata[9:0];
      end
    end
  end

  // Enable and hold masks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      enable_q <= slot_path_pkg::ENABLE_RESET;
      hold_q <= slot_path_pkg::HOLD_RESET;
    end else if (reg_wr) begin
      if (reg_addr == slot_path_pkg::ADDR_ENABLE) begin
        enable_q <= reg_wdata[11:0];
      end else if (reg_addr == slot_path_pkg::ADDR_HOLD) begin
        hold_q <= reg_wdata[11:0];
      end
    end
  end

  // Sticky flags, write one to clear, a set in the same cycle wins
  always_ff @(posedge mclk) begin
    logic [11:0] fclr;
    logic oclr;
    fclr = '0;
    oclr = 1'b0;
    if (reg_wr && (reg_addr == slot_path_pkg::ADDR_DATA_FLAGS)) begin
      fclr = reg_wdata[11:0];
    end
    if (reg_wr && (reg_addr == slot_path_pkg::ADDR_STATUS)) begin
      oclr = reg_wdata[0];
    end
    if (!rst_n) begin
      data_flags <= '0;
      queue_overrun_flag <= 1'b0;
    end else begin
      data_flags <= (data_flags & ~fclr) | flag_set;
      queue_overrun_flag <= (queue_overrun_flag & ~oclr) | overrun_set;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (in_window(reg_addr, slot_path_pkg::ADDR_CFG_BASE)) begin
        reg_rdata <= {19'h0_0000, cfg_q[rd_slot]};
      end else if (in_window(reg_addr, slot_path_pkg::ADDR_SHIFT_BASE)) begin
        reg_rdata <= {22'h00_0000, shift_q[rd_slot]};
      end else if (in_window(reg_addr, slot_path_pkg::ADDR_DARK_BASE)) begin
        reg_rdata <= dark_reg_q[rd_slot];
      end else if (in_window(reg_addr, slot_path_pkg::ADDR_SIGNAL_BASE)) begin
        reg_rdata <= signal_reg_q[rd_slot];
      end else if (reg_addr == slot_path_pkg::ADDR_ENABLE) begin
        reg_rdata <= {20'h0_0000, enable_q};
      end else if (reg_addr == slot_path_pkg::ADDR_HOLD) begin
        reg_rdata <= {20'h0_0000, hold_q};
      end else if (reg_addr == slot_path_pkg::ADDR_DATA_FLAGS) begin
        reg_rdata <= {20'h0_0000, data_flags};
      end else if (reg_addr == slot_path_pkg::ADDR_STATUS) begin
        reg_rdata <= {31'h0000_0000, queue_overrun_flag};
      end else begin
        reg_rdata <= slot_path_pkg::UNMAPPED_READ;
      end
    end
  end

  // ***************************************
  // Sequence counters and slot scheduling
  // ***************************************
  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_slot
      logic at_rate;
      assign at_rate = (seq_cnt_q[g] >= cfg_q[g].rate_reduce_count);

      // Shared count keeps subsample and decimate outputs aligned
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          seq_cnt_q[g] <= '0;
        end else if (seq_end) begin
          seq_cnt_q[g] <= at_rate ? 8'h00 : seq_cnt_q[g] + 8'h01;
        end
      end

      // Enabled slot runs every sequence unless subsampled
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          slot_run_mask[g] <= 1'b0;
        end else begin
          slot_run_mask[g] <= enable_q[g] &
                              (~cfg_q[g].subsample | at_rate);
        end
      end
    end
  endgenerate

  // ***************************************
  // Accumulation
  // ***************************************
  logic to_neg;
  assign to_neg = cfg_q[slot_id].digital_integrate ? smp_dark_region
                                                   : pulse_negate_select;

  // Positive and negative running sums of the active slot
  always_ff @(posedge mclk) begin
    if (!rst_n || slot_start) begin
      pos_q <= '0;
      neg_q <= '0;
    end else if (smp_valid) begin
      if (to_neg) begin
        neg_q <= sat_add(neg_q, smp_data);
      end else begin
        pos_q <= sat_add(pos_q, smp_data);
      end
    end
  end

  // ***************************************
  // Decimation
  // ***************************************
  slot_path_pkg::slot_state_type st_rd;
  slot_path_pkg::slot_state_type st_wr;
  slot_path_pkg::slot_cfg_type cur;
  logic [31:0] lit_val;
  logic [31:0] dark_val;
  logic [31:0] lit_out;
  logic [31:0] dark_out;
  logic [31:0] cic_y;
  logic [3:0][31:0] cic_integ;
  logic [3:0][31:0] cic_comb;
  logic dump;
  logic use_cic;
  slot_path_pkg::slot_result_type res_wr;
  slot_path_pkg::slot_result_type res_rd;

  assign cur = cfg_q[slot_id];
  assign lit_val = clip_pos(pos_q);
  assign dark_val = clip_pos(neg_q);
  assign dump = cur.subsample |
                (seq_cnt_q[slot_id] >= cur.rate_reduce_count);
  assign use_cic = (cur.decimate_type != 3'h0);

  slot_memory #(
    .WIDTH(slot_path_pkg::STATE_W),
    .DEPTH(slot_path_pkg::SLOTS),
    .AW(slot_path_pkg::SLOT_W)
  ) u_state_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(slot_end),
    .wr_addr(slot_id),
    .wr_data(st_wr),
    .rd_en(slot_start),
    .rd_addr(slot_id),
    .rd_data(st_rd)
  );

  cic_step u_cic (
    .order(cur.decimate_type),
    .dump(dump),
    .x(lit_val),
    .integ_in(st_rd.integ),
    .comb_in(st_rd.comb),
    .integ_out(cic_integ),
    .comb_out(cic_comb),
    .y(cic_y)
  );

  // Next decimator state and decimated outputs of the slot
  always_comb begin
    logic [31:0] lsum;
    logic [31:0] dsum;
    lsum = st_rd.integ[0] + lit_val;
    dsum = st_rd.dark_sum + dark_val;
    st_wr = st_rd;
    st_wr.dark_sum = dump ? 32'h0000_0000 : dsum;
    dark_out = dsum;
    if (use_cic) begin
      st_wr.integ = cic_integ;
      st_wr.comb = cic_comb;
      lit_out = cic_y;
    end else begin
      st_wr.integ[0] = dump ? 32'h0000_0000 : lsum;
      lit_out = lsum;
    end
    res_wr.dark = dark_out;
    res_wr.signal = lit_out - dark_out;
  end

  slot_memory #(
    .WIDTH(slot_path_pkg::RESULT_W),
    .DEPTH(slot_path_pkg::SLOTS),
    .AW(slot_path_pkg::SLOT_W)
  ) u_result_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(slot_end & dump),
    .wr_addr(slot_id),
    .wr_data(res_wr),
    .rd_en(emit_q == EMIT_SCAN),
    .rd_addr(emit_idx_q),
    .rd_data(res_rd)
  );

  // Ready marks for slots whose decimated result is waiting
  always_ff @(posedge mclk) begin
    logic [11:0] set;
    set = '0;
    if (slot_end && dump) begin
      set[slot_id] = 1'b1;
    end
    if (!rst_n) begin
      ready_q <= '0;
    end else if (seq_end) begin
      ready_q <= '0;
    end else begin
      ready_q <= ready_q | set;
    end
  end

  // ***************************************
  // Register update and FIFO emission
  // ***************************************
  logic [10:0] need_bytes;
  assign need_bytes = 11'(ones(enable_q)) *
                      11'(slot_path_pkg::BYTES_PER_SLOT);

  // Snapshot at sequence end, then walk the slots in order
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      emit_q <= EMIT_IDLE;
      emit_idx_q <= '0;
      ready_snap_q <= '0;
      space_ok_q <= 1'b0;
    end else begin
      case (emit_q)
        EMIT_IDLE: begin
          if (seq_end) begin
            ready_snap_q <= ready_q;
            space_ok_q <= ({1'b0, fifo_space} >= need_bytes);
            emit_idx_q <= '0;
            emit_q <= EMIT_SCAN;
          end
        end
        EMIT_SCAN: begin
          if (ready_snap_q[emit_idx_q]) begin
            emit_q <= EMIT_DARK;
          end else if (emit_idx_q == 4'hb) begin
            emit_q <= EMIT_IDLE;
          end else begin
            emit_idx_q <= emit_idx_q + 4'h1;
          end
        end
        EMIT_DARK: begin
          emit_q <= EMIT_SIG;
        end
        EMIT_SIG: begin
          if (emit_idx_q == 4'hb) begin
            emit_q <= EMIT_IDLE;
          end else begin
            emit_idx_q <= emit_idx_q + 4'h1;
            emit_q <= EMIT_SCAN;
          end
        end
        default: begin
          emit_q <= EMIT_IDLE;
        end
      endcase
    end
  end

  // Host-visible data registers, frozen by the hold mask
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 12; i++) begin
        dark_reg_q[i] <= '0;
        signal_reg_q[i] <= '0;
      end
    end else if (emit_q == EMIT_DARK && !hold_q[emit_idx_q]) begin
      dark_reg_q[emit_idx_q] <= res_rd.dark;
      signal_reg_q[emit_idx_q] <= res_rd.signal;
    end
  end

  // Flag and overrun event pulses
  always_comb begin
    flag_set = '0;
    if (emit_q == EMIT_DARK) begin
      flag_set[emit_idx_q] = 1'b1;
    end
    overrun_set = (emit_q == EMIT_IDLE) && seq_end &&
                  ({1'b0, fifo_space} < need_bytes);
  end

  // FIFO words, dark then signal, shifted right
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fifo_wr_valid <= 1'b0;
      fifo_wr_data <= '0;
    end else if (emit_q == EMIT_DARK) begin
      fifo_wr_valid <= space_ok_q;
      fifo_wr_data <= res_rd.dark >> shift_q[emit_idx_q].dark_shift;
    end else if (emit_q == EMIT_SIG) begin
      fifo_wr_valid <= space_ok_q;
      fifo_wr_data <= res_rd.signal >>
                      shift_q[emit_idx_q].signal_shift;
    end else begin
      fifo_wr_valid <= 1'b0;
    end
  end

  // Busy while the walk is running or just leaving
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (emit_q != EMIT_IDLE) || seq_end;
    end
  end

endmodule : slot_accumulate_decimate_path

// ### rtl/slot_memory.sv
// Small per-slot memory with registered read data
module slot_memory #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 12,
  parameter int unsigned AW = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Storage write, cleared by reset so every slot starts from zero state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : slot_memory

// ### rtl/slot_path_pkg.sv
// Shared constants and carrier types of the slot accumulate/decimate path
package slot_path_pkg;

  // ***************************************
  // Sizes
  // ***************************************
  localparam int unsigned SLOTS = 12;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned ADC_W = 14;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CIC_MAX = 4;
  localparam int unsigned BYTES_PER_SLOT = 8;
  localparam int unsigned FIFO_BYTES = 512;
  localparam int unsigned SPACE_W = 10;

  // ***************************************
  // Register word addresses
  // ***************************************
  localparam logic [7:0] ADDR_CFG_BASE = 8'h00;
  localparam logic [7:0] ADDR_SHIFT_BASE = 8'h10;
  localparam logic [7:0] ADDR_DARK_BASE = 8'h20;
  localparam logic [7:0] ADDR_SIGNAL_BASE = 8'h30;
  localparam logic [7:0] ADDR_ENABLE = 8'h40;
  localparam logic [7:0] ADDR_HOLD = 8'h41;
  localparam logic [7:0] ADDR_DATA_FLAGS = 8'h42;
  localparam logic [7:0] ADDR_STATUS = 8'h43;

  // ***************************************
  // Reset values and unmapped read data
  // ***************************************
  localparam logic [11:0] ENABLE_RESET = 12'h001;
  localparam logic [11:0] HOLD_RESET = 12'h000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Per-slot configuration word, low 13 bits of the register
  typedef struct packed {
    logic digital_integrate;
    logic subsample;
    logic [2:0] decimate_type;
    logic [7:0] rate_reduce_count;
  } slot_cfg_type;

  // Per-slot output shift word, low 10 bits of the register
  typedef struct packed {
    logic [4:0] signal_shift;
    logic [4:0] dark_shift;
  } slot_shift_type;

  // Per-slot decimator state kept in memory
  typedef struct packed {
    logic [3:0][31:0] integ;
    logic [3:0][31:0] comb;
    logic [31:0] dark_sum;
  } slot_state_type;

  // Per-slot finished result
  typedef struct packed {
    logic [31:0] dark;
    logic [31:0] signal;
  } slot_result_type;

  localparam int unsigned STATE_W = $bits(slot_state_type);
  localparam int unsigned RESULT_W = $bits(slot_result_type);

endpackage : slot_path_pkg

// ### tb/slot_accumulate_decimate_path_test.sv
// Self-checking bench of the slot accumulate/decimate path
module slot_accumulate_decimate_path_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] id;
    logic di;
    logic [13:0] lit;
    logic [13:0] dark;
    logic [31:0] sig;
  } row_type;
  logic mclk = 1'b0;
  logic rst_n, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, fifo_wr_data;
  logic slot_start, slot_end, seq_end, smp_valid, fifo_wr_valid, busy;
  logic pulse_negate_select, smp_dark_region, queue_overrun_flag;
  logic [3:0] slot_id;
  logic [13:0] smp_data;
  logic [9:0] fifo_space;
  logic [11:0] slot_run_mask, data_flags;
  int fail_count = 0;
  int checks = 0;
  int n;
  row_type r;
  row_type rows[4] = '{
    '{4'h0, 1'b0, 14'h0064, 14'h000a, 32'h0000005a},
    '{4'h5, 1'b1, 14'h3fff, 14'h0001, 32'h00003ffe},
    '{4'hb, 1'b0, 14'h0005, 14'h0009, 32'hfffffffc},
    '{4'h3, 1'b1, 14'h0000, 14'h0000, 32'h00000000}};
  // Clock at 125 MHz
  always #4 mclk = ~mclk;
  slot_accumulate_decimate_path dut (.mclk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .slot_start, .slot_end, .slot_id,
    .seq_end, .smp_valid, .smp_data, .pulse_negate_select,
    .smp_dark_region, .fifo_space, .fifo_wr_valid, .fifo_wr_data,
    .slot_run_mask, .busy, .data_flags, .queue_overrun_flag);
  slot_source_model src (.mclk, .busy, .fifo_wr_valid, .fifo_wr_data,
    .slot_start, .slot_end, .slot_id, .seq_end, .smp_valid, .smp_data,
    .pulse_negate_select, .smp_dark_region, .fifo_space);
  // ********
  // Tasks
  // ********
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // Expect exactly one dark and signal word pair in the FIFO
  task pair(input logic [31:0] d, input logic [31:0] s);
    chk(32'(src.got.size()), 32'h2);
    if (src.got.size() == 2) begin
      chk(src.got[0], d);
      chk(src.got[1], s);
    end
    src.got.delete();
  endtask : pair
  task tally_and_finish();
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hung walk
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    {reg_wr, reg_rd, rst_n} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h40, 32'h1);
    rd(8'h41, 32'h0);
    rd(8'h50, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      wr(8'h40, 32'h1 << r.id);
      wr(8'(r.id), 32'(r.di) << 12);
      src.run_slot(r.id, r.lit, r.dark, r.di);
      src.end_seq();
      pair(32'(r.dark), r.sig);
      rd(8'h20 + 8'(r.id), 32'(r.dark));
      rd(8'h30 + 8'(r.id), r.sig);
      chk(32'(data_flags), 32'h1 << r.id);
      wr(8'h42, 32'hfff);
      rd(8'h42, 32'h0);
    end
    // Three-period block sum, then first-order CIC, on slot 1
    wr(8'h40, 32'h2);
    for (int t = 0; t < 2; t++) begin
      wr(8'h01, 32'h2 | (32'(t) << 8));
      for (int k = 1; k <= 3; k++) begin
        src.run_slot(4'h1, 14'h000a * 14'(k), 14'(k), 1'b0);
        src.end_seq();
        if (k < 3) chk(32'(src.got.size()), 32'h0);
      end
      pair(32'h6, 32'h36);
    end
    // Output shift on FIFO words only, on fresh slot 4
    wr(8'h40, 32'h10);
    wr(8'h14, 32'h41);
    src.run_slot(4'h4, 14'h0064, 14'h0008, 1'b0);
    src.end_seq();
    pair(32'h4, 32'h17);
    rd(8'h24, 32'h8);
    wr(8'h14, 32'h0);
    // No room: nothing written, registers still updated
    src.room <= 10'h004;
    src.run_slot(4'h4, 14'h0032, 14'h0007, 1'b0);
    src.end_seq();
    chk(32'(src.got.size()), 32'h0);
    chk(32'(queue_overrun_flag), 32'h1);
    rd(8'h24, 32'h7);
    rd(8'h43, 32'h1);
    wr(8'h43, 32'h1);
    rd(8'h43, 32'h0);
    src.room <= 10'h200;
    // Subsampled slot 2 runs every second period
    wr(8'h40, 32'h4);
    wr(8'h02, 32'h801);
    src.end_seq();
    src.got.delete();
    n = 0;
    repeat (4) begin
      if (slot_run_mask[2] === 1'b1) begin
        n++;
        src.run_slot(4'h2, 14'h0003, 14'h0001, 1'b0);
      end
      src.end_seq();
    end
    chk(32'(n), 32'h2);
    chk(32'(src.got.size()), 32'h4);
    tally_and_finish();
  end
endmodule : slot_accumulate_decimate_path_test

// ### tb/slot_path_sva.sv
// Concurrent checks on the ports of the slot accumulate/decimate path
module slot_path_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic slot_start,
  input wire logic slot_end,
  input wire logic [3:0] slot_id,
  input wire logic seq_end,
  input wire logic smp_valid,
  input wire logic [13:0] smp_data,
  input wire logic pulse_negate_select,
  input wire logic smp_dark_region,
  input wire logic [9:0] fifo_space,
  input wire logic fifo_wr_valid,
  input wire logic [31:0] fifo_wr_data,
  input wire logic [11:0] slot_run_mask,
  input wire logic busy,
  input wire logic [11:0] data_flags,
  input wire logic queue_overrun_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Sequences
  // ********
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Accepted end of sampling period
  sequence walk_start_seq;
    seq_end && !busy;
  endsequence
  // Dark word, signal word, then a gap
  sequence word_pair_seq;
    fifo_wr_valid ##1 fifo_wr_valid ##1 !fifo_wr_valid;
  endsequence
  // ********
  // Assertions
  // ********
  AST_BUSY_START: assert property (walk_start_seq |=> busy)
    else $error("walk did not start after period end");
  AST_BUSY_ENDS: assert property ($rose(busy) |-> ##[1:60] !busy)
    else $error("walk did not finish in time");
  AST_WORD_PAIR: assert property (
    $rose(fifo_wr_valid) |-> word_pair_seq)
    else $error("fifo words not sent as dark and signal pair");
  AST_WORD_IN_WALK: assert property (
    fifo_wr_valid |-> busy || $past(busy))
    else $error("fifo word outside the period walk");
  AST_FLAG_RISE: assert property (
    (data_flags & ~$past(data_flags)) != 12'h000 |-> busy)
    else $error("data flag set outside register update");
  AST_SHORT_OVERRUN: assert property (
    walk_start_seq ##0 (fifo_space < 10'h008) |=> queue_overrun_flag)
    else $error("overrun not flagged on short fifo space");
  AST_NO_PARTIAL: assert property (
    walk_start_seq ##0 (fifo_space < 10'h008) |=> !fifo_wr_valid [*8])
    else $error("words written without room");
  AST_OVERRUN_HOLD: assert property (queue_overrun_flag
    && !(reg_wr && reg_addr == 8'h43 && reg_wdata[0]) |=> queue_overrun_flag)
    else $error("overrun flag lost without clear");
  AST_NO_NEW_OVERRUN: assert property (!queue_overrun_flag
    && !(seq_end && !busy && fifo_space < 10'h060) |=> !queue_overrun_flag)
    else $error("overrun flag set without cause");
  AST_RDATA_HOLD: assert property (
    !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule : slot_path_sva

bind slot_accumulate_decimate_path slot_path_sva chk_i (
  .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .slot_start, .slot_end, .slot_id, .seq_end, .smp_valid, .smp_data,
  .pulse_negate_select, .smp_dark_region, .fifo_space, .fifo_wr_valid,
  .fifo_wr_data, .slot_run_mask, .busy, .data_flags, .queue_overrun_flag
);

// ### tb/slot_source_model.sv
// Pulse sequencer upstream and output FIFO downstream of the slot path
module slot_source_model (
  input wire logic mclk,
  input wire logic busy,
  input wire logic fifo_wr_valid,
  input wire logic [31:0] fifo_wr_data,
  output logic slot_start,
  output logic slot_end,
  output logic [3:0] slot_id,
  output logic seq_end,
  output logic smp_valid,
  output logic [13:0] smp_data,
  output logic pulse_negate_select,
  output logic smp_dark_region,
  output logic [9:0] fifo_space
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got[$];
  logic [9:0] room = 10'h200;
  // Idle link at time zero
  initial begin
    {slot_start, slot_end, seq_end, smp_valid} = 4'h0;
    {pulse_negate_select, smp_dark_region} = 2'h0;
    slot_id = 4'h0;
    smp_data = 14'h0000;
  end
  // Free space seen by the walk
  assign fifo_space = room;
  // FIFO capture of every written word
  always @(posedge mclk) begin
    if (fifo_wr_valid) got.push_back(fifo_wr_data);
  end
  // One slot: a lit then a dark sample; di picks region steering
  task run_slot(input logic [3:0] id, input logic [13:0] lit,
                input logic [13:0] dark, input logic di);
    @(posedge mclk);
    slot_start <= 1'b1;
    slot_id <= id;
    @(posedge mclk);
    slot_start <= 1'b0;
    smp_valid <= 1'b1;
    smp_data <= lit;
    pulse_negate_select <= di;
    smp_dark_region <= 1'b0;
    @(posedge mclk);
    smp_data <= dark;
    pulse_negate_select <= !di;
    smp_dark_region <= di;
    @(posedge mclk);
    smp_valid <= 1'b0;
    smp_data <= ~dark;
    slot_end <= 1'b1;
    @(posedge mclk);
    slot_end <= 1'b0;
  endtask : run_slot
  // Period end, then wait for the walk to finish
  task end_seq();
    @(posedge mclk);
    seq_end <= 1'b1;
    @(posedge mclk);
    seq_end <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 100; k++) begin
      #1;
      if (busy === 1'b0) break;
      @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
  endtask : end_seq
endmodule : slot_source_model
